// >>> common/tps_pkg.sv
// Purpose: Constants shared by the thermal protection supervisor
// Assumes: 20 MHz system clock
// Notes:   Cool-down and restart times are set here in microseconds

package tps_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int COOL_DOWN_US = 1000;
    localparam int RESTART_US = 2000;
    localparam int COOL_DOWN_CYC = COOL_DOWN_US * CLK_MHZ;
    localparam int RESTART_CYC = RESTART_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Sizes and field values
    // ------------------------------------------------------------
    localparam int HS_NUM = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] CAN_FAIL_NONE = 2'h0;
    localparam logic [1:0] CAN_FAIL_TSD = 2'h1;

    // ------------------------------------------------------------
    // Device operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TPS_NORMAL,
        TPS_FAIL_SAFE,
        TPS_RESTART
    } tps_mode_e;

endpackage

// >>> src/tps_sync.sv
// Purpose: Two-stage synchroniser for a vector of comparator levels
// Assumes: Inputs are quasi-static analog comparator outputs
// Notes:   The first stage feeds only the second stage

`timescale 1ns/1ps

module tps_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta_ff;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= '0;
            o_q <= '0;
        end else begin
            meta_ff <= i_d;
            o_q <= meta_ff;
        end
    end

endmodule

// >>> src/tps_flag.sv
// Purpose: Sticky status flag with a guarded software clear
// Assumes: Set and clear are one-cycle or level requests
// Notes:   Set wins over clear in the same cycle

`timescale 1ns/1ps

module tps_flag (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_set,
    input wire logic i_clr,
    input wire logic i_clr_ok,
    // Status
    output logic o_q
);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_q <= 1'b0;
        end else if (i_set) begin
            o_q <= 1'b1;
        end else if (i_clr && i_clr_ok) begin
            o_q <= 1'b0;
        end
    end

endmodule

// >>> src/tps_supervisor.sv
// Purpose: Three-level thermal protection supervisor
// Assumes: Comparator inputs are asynchronous; control inputs synchronous
// Notes:   Flags are sticky and cleared only by the software strobes

`timescale 1ns/1ps

module tps_supervisor
    import tps_pkg::*;
#(
    parameter int HSN = HS_NUM,
    parameter int COOL_CYC = COOL_DOWN_CYC,
    parameter int RST_CYC = RESTART_CYC
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // Temperature comparators
    input wire logic I_OT_REG2,
    input wire logic I_OT_REG3,
    input wire logic I_OT_CAN,
    input wire logic [HSN-1:0] I_OT_HS,
    input wire logic I_PW_MAIN,
    input wire logic I_TSD_MAIN,
    // Configuration and status of the supplies
    input wire logic I_MAIN_ON,
    input wire logic I_REG3_LOAD_SHARE,
    input wire logic I_CAN_NORMAL,
    // Software writes
    input wire logic I_REG2_EN_WR,
    input wire logic I_REG2_EN_DATA,
    input wire logic I_REG3_EN_WR,
    input wire logic I_REG3_EN_DATA,
    input wire logic I_HS_CTRL_A_WR,
    input wire logic I_HS_CTRL_B_WR,
    input wire logic [HSN/2-1:0] I_HS_CTRL_DATA,
    // Software clears
    input wire logic I_CLR_BLOCK_TSD,
    input wire logic I_CLR_REG2_OT,
    input wire logic I_CLR_REG3_OT,
    input wire logic I_CLR_CAN_FAIL,
    input wire logic I_CLR_HS_FAULT,
    input wire logic I_CLR_PW,
    input wire logic I_CLR_DEV_TSD,
    // Output stage controls
    output logic O_REG2_ENABLE,
    output logic O_REG3_ENABLE,
    output logic O_REG3_EN_BIT,
    output logic O_CAN_TX_EN,
    output logic [HSN/2-1:0] O_HS_CTRL_A,
    output logic [HSN/2-1:0] O_HS_CTRL_B,
    // Status flags
    output logic O_BLOCK_TSD,
    output logic O_REG2_OT,
    output logic O_REG3_OT,
    output logic [1:0] O_CAN_FAIL,
    output logic [HSN-1:0] O_HS_FAULT,
    output logic O_PW,
    output logic O_DEV_TSD,
    // Device mode
    output logic O_NORMAL,
    output logic O_FAIL_SAFE,
    output logic O_RESTART
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    localparam int CNT_W = $clog2(COOL_CYC > RST_CYC ? COOL_CYC : RST_CYC) + 1;

    if (HSN < 2 || HSN % 2 != 0) begin : g_bad_hsn
        $error("HSN must be even and at least 2");
    end
    if (COOL_CYC < 1 || RST_CYC < 1) begin : g_bad_cyc
        $error("Cycle counts must be at least 1");
    end

    // ------------------------------------------------------------
    // Comparator synchronisation
    // ------------------------------------------------------------
    localparam int NCMP = HSN + 5;

    logic [NCMP-1:0] cmp_s;
    logic ot_reg2;
    logic ot_reg3;
    logic ot_can;
    logic [HSN-1:0] ot_hs;
    logic pw_main;
    logic tsd_main;

    tps_sync #(.W(NCMP)) u_sync (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_d({I_TSD_MAIN, I_PW_MAIN, I_OT_HS, I_OT_CAN, I_OT_REG3,
              I_OT_REG2}),
        .o_q(cmp_s)
    );

    assign ot_reg2 = cmp_s[0];
    assign ot_reg3 = cmp_s[1];
    assign ot_can = cmp_s[2];
    assign ot_hs = cmp_s[HSN+2:3];
    assign pw_main = cmp_s[HSN+3];
    assign tsd_main = cmp_s[HSN+4];

    // ------------------------------------------------------------
    // Gated overtemperature events
    // ------------------------------------------------------------
    logic hs_any_on;
    logic ev_reg2;
    logic ev_reg3;
    logic ev_can;
    logic ev_hs;
    logic ev_pw;
    logic ev_dev;
    logic block_hot;

    assign hs_any_on = |{O_HS_CTRL_A, O_HS_CTRL_B};
    assign ev_reg2 = ot_reg2 && O_REG2_ENABLE;
    assign ev_reg3 = ot_reg3 && O_REG3_EN_BIT;
    assign ev_can = ot_can && I_CAN_NORMAL;
    assign ev_hs = |ot_hs && hs_any_on;
    assign ev_pw = pw_main && I_MAIN_ON;
    assign ev_dev = tsd_main && I_MAIN_ON;
    assign block_hot = ot_reg2 || ot_reg3 || ot_can || (|ot_hs);

    // ------------------------------------------------------------
    // Second regulator
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_REG2_ENABLE <= 1'b0;
        end else if (ev_reg2) begin
            O_REG2_ENABLE <= 1'b0;
        end else if (I_REG2_EN_WR) begin
            O_REG2_ENABLE <= I_REG2_EN_DATA;
        end
    end

    // ------------------------------------------------------------
    // Third regulator
    // ------------------------------------------------------------
    logic nxt_reg3_en;

    always_comb begin
        nxt_reg3_en = O_REG3_EN_BIT;
        if (I_REG3_EN_WR) begin
            nxt_reg3_en = I_REG3_EN_DATA;
        end
        if (ev_reg3 && !I_REG3_LOAD_SHARE) begin
            nxt_reg3_en = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_REG3_EN_BIT <= 1'b0;
        end else begin
            O_REG3_EN_BIT <= nxt_reg3_en;
        end
    end

    // Load sharing keeps the bit and follows the comparator
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_REG3_ENABLE <= 1'b0;
        end else begin
            O_REG3_ENABLE <= nxt_reg3_en && !ev_reg3;
        end
    end

    // ------------------------------------------------------------
    // CAN transmitter
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_CAN_TX_EN <= 1'b0;
        end else begin
            O_CAN_TX_EN <= I_CAN_NORMAL && !ot_can;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_CAN_FAIL <= CAN_FAIL_NONE;
        end else if (ev_can) begin
            O_CAN_FAIL <= CAN_FAIL_TSD;
        end else if (I_CLR_CAN_FAIL && !ot_can) begin
            O_CAN_FAIL <= CAN_FAIL_NONE;
        end
    end

    // ------------------------------------------------------------
    // High-side switches
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_HS_CTRL_A <= '0;
            O_HS_CTRL_B <= '0;
        end else if (ev_hs) begin
            O_HS_CTRL_A <= '0;
            O_HS_CTRL_B <= '0;
        end else begin
            if (I_HS_CTRL_A_WR) begin
                O_HS_CTRL_A <= I_HS_CTRL_DATA;
            end
            if (I_HS_CTRL_B_WR) begin
                O_HS_CTRL_B <= I_HS_CTRL_DATA;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_HS_FAULT <= '0;
        end else if (ev_hs) begin
            O_HS_FAULT <= '1;
        end else if (I_CLR_HS_FAULT && !(|ot_hs)) begin
            O_HS_FAULT <= '0;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    tps_flag u_blk (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_set(ev_reg2 || ev_reg3 || ev_can || ev_hs),
        .i_clr(I_CLR_BLOCK_TSD),
        .i_clr_ok(!block_hot),
        .o_q(O_BLOCK_TSD)
    );

    tps_flag u_reg2 (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_set(ev_reg2),
        .i_clr(I_CLR_REG2_OT),
        .i_clr_ok(!ot_reg2),
        .o_q(O_REG2_OT)
    );

    tps_flag u_reg3 (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_set(ev_reg3),
        .i_clr(I_CLR_REG3_OT),
        .i_clr_ok(!ot_reg3),
        .o_q(O_REG3_OT)
    );

    tps_flag u_pw (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_set(ev_pw),
        .i_clr(I_CLR_PW),
        .i_clr_ok(!pw_main),
        .o_q(O_PW)
    );

    tps_flag u_dev (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_set(ev_dev),
        .i_clr(I_CLR_DEV_TSD),
        .i_clr_ok(!tsd_main && O_NORMAL),
        .o_q(O_DEV_TSD)
    );

    // ------------------------------------------------------------
    // Device mode sequencer
    // ------------------------------------------------------------
    tps_mode_e mode_ff;
    tps_mode_e nxt_mode;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb begin
        nxt_mode = mode_ff;
        nxt_cnt = cnt_ff;
        case (mode_ff)
            TPS_NORMAL: begin
                if (ev_dev) begin
                    nxt_mode = TPS_FAIL_SAFE;
                    nxt_cnt = CNT_W'(COOL_CYC - 1);
                end
            end
            TPS_FAIL_SAFE: begin
                if (cnt_ff == '0) begin
                    nxt_mode = TPS_RESTART;
                    nxt_cnt = CNT_W'(RST_CYC - 1);
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            TPS_RESTART: begin
                if (ev_dev) begin
                    nxt_mode = TPS_FAIL_SAFE;
                    nxt_cnt = CNT_W'(COOL_CYC - 1);
                end else if (cnt_ff == '0) begin
                    nxt_mode = TPS_NORMAL;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_mode = TPS_NORMAL;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mode_ff <= TPS_NORMAL;
            cnt_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_NORMAL <= 1'b1;
            O_FAIL_SAFE <= 1'b0;
            O_RESTART <= 1'b0;
        end else begin
            O_NORMAL <= nxt_mode == TPS_NORMAL;
            O_FAIL_SAFE <= nxt_mode == TPS_FAIL_SAFE;
            O_RESTART <= nxt_mode == TPS_RESTART;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reg2_trip: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ev_reg2 |=> !O_REG2_ENABLE && O_REG2_OT && O_BLOCK_TSD)
        else $error("Second regulator not tripped");

    a_reg3_alone: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ev_reg3 && !I_REG3_LOAD_SHARE |=> !O_REG3_EN_BIT && !O_REG3_ENABLE)
        else $error("Stand-alone third regulator not tripped");

    a_reg3_share: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ev_reg3 && I_REG3_LOAD_SHARE && !I_REG3_EN_WR
        |=> O_REG3_EN_BIT && !O_REG3_ENABLE && O_REG3_OT)
        else $error("Load-sharing third regulator mishandled");

    a_can_recv: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ev_can |=> !O_CAN_TX_EN && O_CAN_FAIL == CAN_FAIL_TSD)
        else $error("CAN transmitter not disabled");

    a_hs_all_off: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ev_hs |=> O_HS_CTRL_A == '0 && O_HS_CTRL_B == '0 && &O_HS_FAULT)
        else $error("High-side switches not all off");

    a_blk_sticky: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_BLOCK_TSD && block_hot |=> O_BLOCK_TSD)
        else $error("Block flag cleared while hot");

    a_pw_gated: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        $rose(O_PW) |-> $past(I_MAIN_ON) && $past(pw_main))
        else $error("Prewarning set while main regulator off");

    a_fs_entry: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_NORMAL && ev_dev |=> O_FAIL_SAFE && O_DEV_TSD)
        else $error("Fail-safe not entered on device shutdown");

    a_dev_keep: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_DEV_TSD && !O_NORMAL |=> O_DEV_TSD)
        else $error("Device flag cleared outside normal mode");

    a_sync_lag: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        $rose(tsd_main) |-> $past(I_TSD_MAIN, 2))
        else $error("Comparator used without synchronisation");

endmodule

// >>> tb/tps_host.sv
// Purpose: Host model issuing software writes and flag clears
// Assumes: Strobes last one cycle and change on the falling edge
// Notes:   Data bus shows the inverse of the last value when idle

`timescale 1ns/1ps

module tps_host (
    // Clock
    input wire logic i_clk,
    // Software writes
    output logic o_reg2_wr,
    output logic o_reg2_data,
    output logic o_reg3_wr,
    output logic o_reg3_data,
    output logic o_hs_a_wr,
    output logic o_hs_b_wr,
    output logic [1:0] o_hs_data,
    // Software clears
    output logic [6:0] o_clr
);
    logic [3:0] wr_q = 4'h0;
    logic [1:0] d_q = 2'h2;

    initial begin
        o_clr = 7'h00;
    end

    assign o_reg2_wr = wr_q[0];
    assign o_reg3_wr = wr_q[1];
    assign o_hs_a_wr = wr_q[2];
    assign o_hs_b_wr = wr_q[3];
    assign o_reg2_data = d_q[0];
    assign o_reg3_data = d_q[0];
    assign o_hs_data = d_q;

    // ------------------------------------------------------------
    // Write and clear strobes
    // ------------------------------------------------------------
    task automatic wr(input int k, input logic [1:0] d);
        @(negedge i_clk);
        d_q = d;
        wr_q[k] = 1'b1;
        @(negedge i_clk);
        wr_q = 4'h0;
        d_q = ~d;
    endtask

    task automatic clr(input int k);
        @(negedge i_clk);
        o_clr[k] = 1'b1;
        @(negedge i_clk);
        o_clr = 7'h00;
    endtask

    task automatic reen3;
        clr(2);
        wr(1, 2'h1);
    endtask
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the thermal protection supervisor
// Assumes: Short cool-down and restart counts
// Notes:   Inputs change on the falling edge

`timescale 1ns/1ps

module testbench;
    import tps_pkg::*;
    localparam int CC = 4;
    localparam int RC = 3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ot2 = 1'b0, ot3 = 1'b0, otc = 1'b0, pw = 1'b0, tsd = 1'b0;
    logic [3:0] oths = 4'h0;
    logic main_on = 1'b0, ls = 1'b0, can_n = 1'b0;
    logic r2_wr, r2_d, r3_wr, r3_d, a_wr, b_wr;
    logic [1:0] hs_d, ca, cb, cf;
    logic [6:0] clr;
    logic en2, en3, bit3, tx, btsd, ot2f, ot3f, pwf, dtsd, nrm, fs, rs;
    logic [3:0] hf;
    int fail_count = 0;
    int comparisons = 0;
    int k;

    always #25 clk = ~clk;

    tps_supervisor #(.HSN(4), .COOL_CYC(CC), .RST_CYC(RC)) tps_supervisor_i (
        .I_CLK(clk), .I_SYS_RST(rst),
        .I_OT_REG2(ot2), .I_OT_REG3(ot3), .I_OT_CAN(otc), .I_OT_HS(oths),
        .I_PW_MAIN(pw), .I_TSD_MAIN(tsd), .I_MAIN_ON(main_on),
        .I_REG3_LOAD_SHARE(ls), .I_CAN_NORMAL(can_n),
        .I_REG2_EN_WR(r2_wr), .I_REG2_EN_DATA(r2_d),
        .I_REG3_EN_WR(r3_wr), .I_REG3_EN_DATA(r3_d),
        .I_HS_CTRL_A_WR(a_wr), .I_HS_CTRL_B_WR(b_wr), .I_HS_CTRL_DATA(hs_d),
        .I_CLR_BLOCK_TSD(clr[0]), .I_CLR_REG2_OT(clr[1]),
        .I_CLR_REG3_OT(clr[2]), .I_CLR_CAN_FAIL(clr[3]),
        .I_CLR_HS_FAULT(clr[4]), .I_CLR_PW(clr[5]), .I_CLR_DEV_TSD(clr[6]),
        .O_REG2_ENABLE(en2), .O_REG3_ENABLE(en3), .O_REG3_EN_BIT(bit3),
        .O_CAN_TX_EN(tx), .O_HS_CTRL_A(ca), .O_HS_CTRL_B(cb),
        .O_BLOCK_TSD(btsd), .O_REG2_OT(ot2f), .O_REG3_OT(ot3f),
        .O_CAN_FAIL(cf), .O_HS_FAULT(hf), .O_PW(pwf), .O_DEV_TSD(dtsd),
        .O_NORMAL(nrm), .O_FAIL_SAFE(fs), .O_RESTART(rs)
    );

    tps_host tps_host_i (
        .i_clk(clk), .o_reg2_wr(r2_wr), .o_reg2_data(r2_d),
        .o_reg3_wr(r3_wr), .o_reg3_data(r3_d), .o_hs_a_wr(a_wr),
        .o_hs_b_wr(b_wr), .o_hs_data(hs_d), .o_clr(clr)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp,
                       input string m);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic clr_blk(input int n);
        tps_host_i.clr(n);
        tps_host_i.clr(0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reg2;
        ot2 = 1'b1;
        cyc(4);
        chk({ot2f, btsd}, 2'b00, "reg2 off ignored");
        ot2 = 1'b0;
        tps_host_i.wr(0, 2'h1);
        cyc(4);
        ot2 = 1'b1;
        cyc(2);
        chk(en2, 1'b1, "sync delay");
        cyc(2);
        chk({en2, ot2f, btsd}, 3'b011, "reg2 trip");
        clr_blk(1);
        chk({ot2f, btsd}, 2'b11, "clear while hot");
        ot2 = 1'b0;
        cyc(6);
        chk({en2, ot2f, btsd}, 3'b011, "reg2 stays off");
        clr_blk(1);
        chk({ot2f, btsd}, 2'b00, "clear when cool");
    endtask

    task automatic t_reg3;
        tps_host_i.wr(1, 2'h1);
        ot3 = 1'b1;
        cyc(4);
        chk({en3, bit3, ot3f}, 3'b001, "reg3 alone trip");
        ot3 = 1'b0;
        cyc(4);
        chk({en3, bit3}, 2'b00, "reg3 stays off");
        tps_host_i.reen3();
        cyc(2);
        chk({en3, bit3, ot3f}, 3'b110, "reg3 re-enabled");
        ls = 1'b1;
        ot3 = 1'b1;
        cyc(4);
        chk({en3, bit3, ot3f}, 3'b011, "reg3 shared trip");
        ot3 = 1'b0;
        cyc(4);
        chk({en3, bit3, ot3f}, 3'b111, "reg3 shared back");
        clr_blk(2);
        chk({ot3f, btsd}, 2'b00, "reg3 clear");
    endtask

    task automatic t_can_hs;
        otc = 1'b1;
        cyc(4);
        chk({tx, cf}, 3'b000, "can off ignored");
        otc = 1'b0;
        cyc(3);
        tps_host_i.wr(2, 2'h3);
        tps_host_i.wr(3, 2'h1);
        can_n = 1'b1;
        otc = 1'b1;
        cyc(4);
        chk({tx, cf}, 3'b001, "can trip");
        chk({ca, cb}, 4'hd, "switches untouched");
        otc = 1'b0;
        cyc(4);
        chk({tx, cf}, 3'b101, "can back");
        clr_blk(3);
        chk(cf, 2'h0, "can clear");
        oths = 4'h8;
        cyc(4);
        chk({ca, cb}, 4'h0, "all switches off");
        chk(hf, 4'hf, "switch faults");
        oths = 4'h0;
        cyc(4);
        chk(hf, 4'hf, "faults sticky");
        clr_blk(4);
        chk(hf, 4'h0, "fault clear");
        oths = 4'h1;
        cyc(4);
        chk(hf, 4'h0, "switches off ignored");
        chk(btsd, 1'b0, "no block event");
        oths = 4'h0;
        cyc(3);
    endtask

    task automatic t_dev;
        pw = 1'b1;
        tsd = 1'b1;
        cyc(4);
        chk({pwf, dtsd, fs}, 3'b000, "main off ignored");
        main_on = 1'b1;
        for (k = 0; k < 10 && fs !== 1'b1; k++) cyc(1);
        chk(fs, 1'b1, "fail-safe entry");
        if (fs !== 1'b1) end_sim();
        tsd = 1'b0;
        for (k = 0; k < 50 && fs === 1'b1; k++) cyc(1);
        chk(k[3:0], 4'(CC), "cool-down length");
        for (k = 0; k < 50 && rs === 1'b1; k++) cyc(1);
        chk(k[3:0], 4'(RC), "restart length");
        chk({nrm, dtsd, pwf}, 3'b111, "back to normal");
        tps_host_i.clr(5);
        chk(pwf, 1'b1, "prewarn clear while hot");
        pw = 1'b0;
        cyc(3);
        tps_host_i.clr(5);
        tps_host_i.clr(6);
        chk({pwf, dtsd}, 2'b00, "prewarn and device clear");
    endtask

    task automatic t_dev_again;
        tsd = 1'b1;
        for (k = 0; k < 10 && fs !== 1'b1; k++) cyc(1);
        tsd = 1'b0;
        for (k = 0; k < 50 && rs !== 1'b1; k++) cyc(1);
        chk(rs, 1'b1, "restart reached");
        tsd = 1'b1;
        cyc(3);
        chk({fs, rs}, 2'b10, "event in restart");
        tsd = 1'b0;
        cyc(3);
        tps_host_i.clr(6);
        chk({rs, dtsd}, 2'b11, "device clear outside normal");
        for (k = 0; k < 20 && nrm !== 1'b1; k++) cyc(1);
        tps_host_i.clr(6);
        chk({nrm, dtsd}, 2'b10, "device clear in normal");
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        cyc(1);
        chk({nrm, fs, rs, btsd}, 4'h8, "reset state");
        t_reg2();
        t_reg3();
        t_can_hs();
        t_dev();
        t_dev_again();
        end_sim();
    end
endmodule
